// file: rtl/brake_sequencer_current_limiter.sv
// Brake and motor-current sequencer with a current-squared-time overload limiter.
// Assumes a host object port that is synchronous to sys_clk and one request at a time.
`timescale 1ns/10ps
`default_nettype none
module brake_sequencer_current_limiter
  import brake_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
  input  wire logic        sys_clk,        // 40 MHz system clock.
  input  wire logic        rst_n,          // Asynchronous reset, active low.
  input  wire od_req_t     od_req,         // Host object access request.
  output od_rsp_t          od_rsp_q,       // Host object access answer.
  input  wire logic        op_enable_req,  // Power state machine wants operation enabled.
  input  wire logic [15:0] meas_ma,        // Measured motor current in mA.
  input  wire logic [15:0] cur_cmd_ma,     // Current command before clamping.
  output drive_out_t       drv_q,          // Current, brake and motion controls.
  output logic      [15:0] cur_clamp_q,    // Clamped current command in mA.
  output logic      [15:0] applied_current_limit_q, // Applied limit in mA.
  output logic             limiter_active_q          // Limiter status.
);
  // One decode serves writes, reads and the error flag, so the three never disagree.
  function automatic od_sel_t od_decode(input logic [15:0] idx, input logic [7:0] sub);
    od_sel_t s;
    s = SEL_NONE;
    case (idx)
      IDX_MAX_MOTOR: if (sub == SUB_ZERO) s = SEL_MM;
      IDX_BRAKE_TM:  if (sub >= SUB_ONE && sub <= SUB_TM_LAST) s = SEL_TM;
      IDX_OVERLOAD: begin
        case (sub)
          SUB_RATED:   s = SEL_RATED;
          SUB_PEAK:    s = SEL_PEAK;
          SUB_THRESH:  s = SEL_THR;
          SUB_CALC:    s = SEL_CALC;
          SUB_LIMITED: s = SEL_LIM;
          SUB_STATUS:  s = SEL_STAT;
          default:     s = SEL_NONE;
        endcase
      end
      IDX_SUBMODE:   if (sub == SUB_ZERO) s = SEL_SUBMODE;
      IDX_MAX_PCT:   if (sub == SUB_ZERO) s = SEL_PCT;
      IDX_DOUT:      if (sub == SUB_ONE) s = SEL_DOUT;
      default:       s = SEL_NONE;
    endcase
    return s;
  endfunction

  // Each waiting state reads the delay word that ends it.
  function automatic logic [1:0] tm_word(input brake_state_t st);
    case (st)
      ST_PRE_REL:  return TM_ON_TO_REL;
      ST_POST_REL: return TM_REL_TO_RUN;
      ST_PRE_ENG:  return TM_STOP_TO_ENG;
      ST_POST_ENG: return TM_ENG_TO_OFF;
      default:     return TM_STOP_TO_ENG;
    endcase
  endfunction

  // Object storage and access decode.
  logic [31:0] mm_q, rated_q, peak_q, submode_q, dout_q;
  logic [15:0] pct_q;
  od_sel_t     sel;
  logic        sel_ro, wr_ok;
  logic        rd1_q, err1_q, tm1_q;
  logic [31:0] data1_q, rd_local, tm_b;

  assign sel    = od_decode(od_req.index, od_req.sub);
  assign sel_ro = sel inside {SEL_THR, SEL_CALC, SEL_LIM, SEL_STAT};
  assign wr_ok  = od_req.wr && sel != SEL_NONE && !sel_ro;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mm_q      <= WORD_RST;
      rated_q   <= WORD_RST;
      peak_q    <= WORD_RST;
      submode_q <= SUBMODE_RST;
      pct_q     <= PCT_RST;
      dout_q    <= WORD_RST;
    end else if (wr_ok) begin
      case (sel)
        SEL_MM:      mm_q      <= od_req.wdata;
        SEL_RATED:   rated_q   <= od_req.wdata;
        SEL_PEAK:    peak_q    <= od_req.wdata;
        SEL_SUBMODE: submode_q <= od_req.wdata;
        SEL_PCT:     pct_q     <= od_req.wdata[15:0];
        SEL_DOUT:    dout_q    <= od_req.wdata;
        default:     ;
      endcase
    end
  end

  // Millisecond tick; it restarts with each delay so no delay runs short.
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick, arm_q;
  assign tick = (tick_cnt_q == TICK_W'(MS_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (arm_q || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Brake sequencer.
  brake_state_t state_q, state_d;
  logic [31:0]  tm_a, dly_q;
  logic         auto_mode, done;
  drive_out_t   drv_d;

  assign auto_mode = submode_q[BIT_AUTO_BRK];
  assign done = arm_q ? (tm_a == 32'h0) : (tick && dly_q == 32'h1);

  timing_store u_tm (
    .sys_clk (sys_clk),
    .we      (wr_ok && sel == SEL_TM),
    .waddr   (2'(od_req.sub - SUB_ONE)),
    .wdata   (od_req.wdata),
    .raddr_a (tm_word(state_d)),
    .rdata_a (tm_a),
    .raddr_b (2'(od_req.sub - SUB_ONE)),
    .rdata_b (tm_b)
  );

  // Manual mode parks the sequencer, so a return to automatic starts from a held brake.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HELD:     if (op_enable_req) state_d = ST_PRE_REL;
      ST_PRE_REL:  if (!op_enable_req) state_d = ST_HELD;
                   else if (done) state_d = ST_POST_REL;
      ST_POST_REL: if (!op_enable_req) state_d = ST_PRE_ENG;
                   else if (done) state_d = ST_RUN;
      ST_RUN:      if (!op_enable_req) state_d = ST_PRE_ENG;
      ST_PRE_ENG:  if (done) state_d = ST_POST_ENG;
      ST_POST_ENG: if (done) state_d = ST_HELD;
      default:     state_d = ST_HELD;
    endcase
    if (!auto_mode) begin
      state_d = ST_HELD;
    end
  end

  // In automatic mode outputs follow the next state so they line up with state_q.
  always_comb begin
    if (auto_mode) begin
      drv_d.current_on    = state_d != ST_HELD;
      drv_d.brake_release = state_d inside {ST_POST_REL, ST_RUN, ST_PRE_ENG};
      drv_d.motion_ok     = state_d == ST_RUN;
      drv_d.stop_motor    = state_d inside {ST_PRE_ENG, ST_POST_ENG};
    end else begin
      drv_d.current_on    = op_enable_req;
      drv_d.brake_release = dout_q[BIT_MAN_BRK];
      drv_d.motion_ok     = op_enable_req;
      drv_d.stop_motor    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_HELD;
      arm_q   <= 1'b0;
      dly_q   <= '0;
      drv_q   <= '0;
    end else begin
      state_q <= state_d;
      arm_q   <= state_d != state_q;
      drv_q   <= drv_d;
      if (arm_q) begin
        dly_q <= tm_a;
      end else if (tick && dly_q != 32'h0) begin
        dly_q <= dly_q - 32'h1;
      end
    end
  end

  // Overload limiter; currents use the low 16 bits of each object.
  logic [15:0] rated16, mm16, cap16;
  logic [31:0] pct_ma, cap_ma, sq_cap, sq_rat, sq_meas, heat_cool;
  logic [63:0] limit_d, limit_q, heat_q, heat_d, heat_up;
  logic        lim_ok, over;

  assign rated16 = rated_q[15:0];
  assign mm16    = mm_q[15:0];
  assign pct_ma  = (rated16 * pct_q) / PERMILLE;
  assign cap_ma  = (pct_ma > {16'h0, mm16}) ? {16'h0, mm16} : pct_ma;
  assign cap16   = cap_ma[15:0];
  assign lim_ok  = submode_q[BIT_CLOSED] && cap_ma > {16'h0, rated16}
                   && peak_q != 32'h0;
  assign sq_cap  = cap16 * cap16;
  assign sq_rat  = rated16 * rated16;
  assign sq_meas = meas_ma * meas_ma;
  assign limit_d = {32'h0, sq_cap - sq_rat} * {32'h0, peak_q};
  // The comparison runs every cycle; the accumulated value moves on a tick, and clears in any cycle while the limiter is inactive.
  assign over    = heat_q >= limit_q;
  assign heat_up = heat_q + {32'h0, sq_meas - sq_rat};
  assign heat_cool = sq_rat - sq_meas;

  // Heat saturates at the limit, so cooling shows at the first tick after the load drops.
  always_comb begin
    heat_d = heat_q;
    if (!limiter_active_q) begin
      heat_d = '0;
    end else if (tick && sq_meas > sq_rat) begin
      heat_d = (heat_up > limit_q) ? limit_q : heat_up;
    end else if (tick) begin
      heat_d = (heat_q > {32'h0, heat_cool}) ? heat_q - {32'h0, heat_cool} : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_q                 <= '0;
      heat_q                  <= '0;
      limiter_active_q        <= 1'b0;
      applied_current_limit_q <= '0;
      cur_clamp_q             <= '0;
    end else begin
      limit_q                 <= limit_d;
      heat_q                  <= heat_d;
      limiter_active_q        <= lim_ok;
      applied_current_limit_q <= (limiter_active_q && over) ? rated16 : cap16;
      cur_clamp_q <= (cur_cmd_ma > applied_current_limit_q) ? applied_current_limit_q
                                                            : cur_cmd_ma;
    end
  end

  // Host answers two cycles after the request; both stages are registered.
  always_comb begin
    case (sel)
      SEL_MM:      rd_local = mm_q;
      SEL_RATED:   rd_local = rated_q;
      SEL_PEAK:    rd_local = peak_q;
      SEL_THR:     rd_local = 32'(limit_q / MA2_PER_A2);
      SEL_CALC:    rd_local = 32'(heat_q / MA2_PER_A2);
      SEL_LIM:     rd_local = {16'h0, applied_current_limit_q};
      SEL_STAT:    rd_local = {31'h0, limiter_active_q};
      SEL_SUBMODE: rd_local = submode_q;
      SEL_PCT:     rd_local = {16'h0, pct_q};
      SEL_DOUT:    rd_local = dout_q;
      default:     rd_local = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd1_q    <= 1'b0;
      err1_q   <= 1'b0;
      tm1_q    <= 1'b0;
      data1_q  <= '0;
      od_rsp_q <= '0;
    end else begin
      rd1_q    <= od_req.rd || od_req.wr;
      err1_q   <= sel == SEL_NONE || (od_req.wr && sel_ro);
      tm1_q    <= od_req.rd && sel == SEL_TM;
      data1_q  <= od_req.rd ? rd_local : 32'h0;
      od_rsp_q.ack   <= rd1_q;
      od_rsp_q.err   <= rd1_q && err1_q;
      od_rsp_q.rdata <= tm1_q ? tm_b : data1_q;
    end
  end

  sequence s_enter_enable;
    state_q == ST_HELD ##1 state_q == ST_PRE_REL;
  endsequence

  sequence s_release_done;
    state_q == ST_POST_REL ##1 state_q == ST_RUN;
  endsequence

  // Sequencer checks; outputs lag the mode bit by a cycle, so a fresh switch is excluded.
  chk_brake_held_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_mode && $past(auto_mode) && state_q inside {ST_HELD, ST_PRE_REL})
    |-> !drv_q.brake_release)
    else $error("Brake released while not enabled.");
  chk_submode_reset: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> submode_q[BIT_AUTO_BRK])
    else $error("Automatic brake bit not set after reset.");
  chk_manual_brake_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !auto_mode |=> drv_q.brake_release == $past(dout_q[BIT_MAN_BRK]))
    else $error("Manual brake does not follow output bit.");
  chk_enable_current_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_enter_enable |-> drv_q.current_on && !drv_q.brake_release && !drv_q.motion_ok)
    else $error("Enable order wrong.");
  chk_motion_after_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_release_done |-> drv_q.motion_ok && drv_q.brake_release && $past(drv_q.brake_release))
    else $error("Motion allowed before brake release.");
  chk_engage_before_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_mode && state_q == ST_POST_ENG) |-> drv_q.current_on && !drv_q.brake_release)
    else $error("Current off before brake engaged.");
  chk_zero_delay_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (arm_q && tm_a == 32'h0 && auto_mode && op_enable_req && state_q == ST_PRE_REL)
    |=> state_q == ST_POST_REL)
    else $error("Zero delay did not pass straight on.");
  // Limiter checks.
  chk_limiter_closed_loop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!submode_q[BIT_CLOSED] || peak_q == 32'h0) |=> !limiter_active_q)
    else $error("Limiter active without closed loop or duration.");
  chk_clamp_to_rated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (limiter_active_q && heat_q >= limit_q) |=> applied_current_limit_q == $past(rated16))
    else $error("Limit not clamped to rated current.");
  chk_cap_motor_max: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> applied_current_limit_q <= $past(mm16))
    else $error("Applied limit above maximum motor current.");
  chk_cool_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (limiter_active_q && tick && meas_ma < rated16 && heat_q != 64'h0)
    |=> heat_q < $past(heat_q))
    else $error("Accumulated value did not decay.");

  // Further checks on the delay load, the travel gate, the limiter's enable condition and its below-limit outcome.
  chk_delay_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    arm_q |=> dly_q == $past(tm_a))
    else $error("Delay not loaded on entering a step.");
  chk_motion_needs_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_mode && $past(auto_mode) && drv_q.motion_ok)
    |-> drv_q.brake_release && drv_q.current_on)
    else $error("Travel allowed with brake held or current off.");
  chk_limiter_cap_rated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cap_ma <= {16'h0, rated16}) |=> !limiter_active_q)
    else $error("Limiter active although maximum does not exceed rated.");
  chk_max_below_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (limiter_active_q && heat_q < limit_q) |=> applied_current_limit_q == $past(cap16))
    else $error("Maximum current withheld below the limit.");
endmodule // brake_sequencer_current_limiter
`default_nettype wire

// file: rtl/brake_pkg.sv
// Constants, object map and carrier types for the brake sequencer and overload limiter.
// Assumes one 40 MHz system clock and a host that reaches objects by index and subindex.
package brake_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W       = 16;

  localparam logic [15:0] IDX_MAX_MOTOR = 16'h2031;
  localparam logic [15:0] IDX_BRAKE_TM  = 16'h2038;
  localparam logic [15:0] IDX_OVERLOAD  = 16'h203B;
  localparam logic [15:0] IDX_SUBMODE   = 16'h3202;
  localparam logic [15:0] IDX_MAX_PCT   = 16'h6073;
  localparam logic [15:0] IDX_DOUT      = 16'h60FE;

  localparam logic [7:0]  SUB_ZERO      = 8'h00;
  localparam logic [7:0]  SUB_ONE       = 8'h01;
  localparam logic [7:0]  SUB_TM_LAST   = 8'h04;
  localparam logic [7:0]  SUB_RATED     = 8'h01;
  localparam logic [7:0]  SUB_PEAK      = 8'h02;
  localparam logic [7:0]  SUB_THRESH    = 8'h03;
  localparam logic [7:0]  SUB_CALC      = 8'h04;
  localparam logic [7:0]  SUB_LIMITED   = 8'h05;
  localparam logic [7:0]  SUB_STATUS    = 8'h06;

  localparam logic [31:0] SUBMODE_RST   = 32'h0000_0004;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;
  localparam logic [15:0] PCT_RST       = 16'h0000;
  localparam int unsigned BIT_CLOSED    = 0;
  localparam int unsigned BIT_AUTO_BRK  = 2;
  localparam int unsigned BIT_MAN_BRK   = 0;

  localparam logic [31:0] PERMILLE      = 32'h0000_03E8;
  localparam logic [63:0] MA2_PER_A2    = 64'h0000_0000_000F_4240;

  localparam logic [1:0]  TM_STOP_TO_ENG = 2'h0;
  localparam logic [1:0]  TM_ENG_TO_OFF  = 2'h1;
  localparam logic [1:0]  TM_ON_TO_REL   = 2'h2;
  localparam logic [1:0]  TM_REL_TO_RUN  = 2'h3;

  typedef enum logic [2:0] {
    ST_HELD, ST_PRE_REL, ST_POST_REL, ST_RUN, ST_PRE_ENG, ST_POST_ENG
  } brake_state_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_MM, SEL_TM, SEL_RATED, SEL_PEAK, SEL_THR, SEL_CALC,
    SEL_LIM, SEL_STAT, SEL_SUBMODE, SEL_PCT, SEL_DOUT
  } od_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } od_rsp_t;

  typedef struct packed {
    logic current_on;
    logic brake_release;
    logic motion_ok;
    logic stop_motor;
  } drive_out_t;
endpackage

// file: rtl/timing_store.sv
// Four-word store for the brake timing delays, one write port and two read ports.
// Read data come from registers, so each read returns one cycle after its address.
`timescale 1ns/10ps
`default_nettype none
module timing_store (
  input  wire logic        sys_clk,  // System clock.
  input  wire logic        we,       // Write strobe.
  input  wire logic [1:0]  waddr,    // Write word.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [1:0]  raddr_a,  // Sequencer read word.
  output logic      [31:0] rdata_a,  // Sequencer read data.
  input  wire logic [1:0]  raddr_b,  // Host read word.
  output logic      [31:0] rdata_b   // Host read data.
);
  logic [31:0] mem [4];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule // timing_store
`default_nettype wire

// file: dv/motor_load_model.sv
// Behavioural motor winding seen from the drive: current follows the clamped command.
// Assumes the drive outputs and the clamp come straight from the sequencer's registers.
`timescale 1ns/10ps
`default_nettype none
module motor_load_model
  import brake_pkg::*;
(
  input  wire drive_out_t  drv,      // Drive controls from the block.
  input  wire logic [15:0] cmd_ma,   // Clamped current command in mA.
  output logic      [15:0] meas_ma   // Measured winding current in mA.
);
  // An unpowered winding carries nothing, so the limiter cools while the drive current is off.
  assign meas_ma = drv.current_on ? cmd_ma : 16'h0000;
endmodule // motor_load_model
`default_nettype wire

// file: dv/brake_sequencer_current_limiter_bench.sv
// Self-checking bench for the brake sequencer and overload limiter.
// Assumes a short millisecond tick set through MS_CYCLES and the motor model beside it.
`timescale 1ns/10ps
`default_nettype none
module brake_sequencer_current_limiter_bench
  import brake_pkg::*;
;
  localparam int MS = 8;
  logic        sys_clk, rst_n, op_enable_req, limiter_active_q, erv;
  od_req_t     od_req;
  od_rsp_t     od_rsp_q;
  drive_out_t  drv_q;
  logic [15:0] meas_ma, cur_cmd_ma, cur_clamp_q, applied_current_limit_q;
  logic [31:0] rdv;
  int          error_cnt, checks, seed, n, pct;
  int          d[1:4];

  brake_sequencer_current_limiter #(.MS_CYCLES(MS)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .od_req(od_req), .od_rsp_q(od_rsp_q),
    .op_enable_req(op_enable_req), .meas_ma(meas_ma), .cur_cmd_ma(cur_cmd_ma),
    .drv_q(drv_q), .cur_clamp_q(cur_clamp_q),
    .applied_current_limit_q(applied_current_limit_q),
    .limiter_active_q(limiter_active_q));

  motor_load_model model_u (.drv(drv_q), .cmd_ma(cur_clamp_q), .meas_ma(meas_ma));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One object access; the answer stands between the first and second edges after the taking edge.
  task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                    input logic [31:0] wd);
    @(posedge sys_clk);
    od_req <= '{wr: w, rd: !w, index: ix, sub: sb, wdata: wd};
    @(posedge sys_clk);
    od_req <= '0;
    @(posedge sys_clk);
    #1;
    chk("ack", od_rsp_q.ack, 1'b1);
    rdv = od_rsp_q.rdata;
    erv = od_rsp_q.err;
  endtask

  task automatic wt(input int k, input logic v);
    n = 0;
    while (drv_q[k] !== v && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic wl(input logic [15:0] v);
    n = 0;
    while (applied_current_limit_q !== v && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  // A delay may land a cycle early or a few late, since the tick restarts per step.
  function automatic logic [31:0] near(input int lo);
    return (n + 1 >= lo && n <= lo + 4);
  endfunction

  function automatic logic [15:0] cap_of(input int p);
    return (p > 3000) ? 16'(3000) : 16'(p);
  endfunction

  function automatic logic [31:0] thr(input longint c);
    return 32'(((c * c - 64'd1000000) * 2) / 1000000);
  endfunction

  initial begin
    seed = 74;
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    op_enable_req = 1'b0;
    od_req = '0;
    cur_cmd_ma = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("drv", drv_q, 4'h0);
    od(0, IDX_SUBMODE, SUB_ZERO, 0);
    chk("submode", rdv, 32'h0000_0004);
    od(0, IDX_OVERLOAD, SUB_STATUS, 0);
    chk("status", rdv, 32'h0);
    od(0, 16'h1234, SUB_ZERO, 0);
    chk("unmapped", erv, 1'b1);
    od(1, IDX_OVERLOAD, SUB_THRESH, 32'h5);
    chk("ro", erv, 1'b1);
    for (int r = 0; r < 2; r++) begin
      for (int i = 1; i <= 4; i++) begin
        d[i] = r ? 0 : 1 + {$random(seed)} % 3;
        od(1, IDX_BRAKE_TM, 8'(i), d[i]);
        od(0, IDX_BRAKE_TM, 8'(i), 0);
        chk("timing", rdv, d[i]);
      end
      @(posedge sys_clk);
      op_enable_req <= 1'b1;
      wt(3, 1'b1);
      chk("on", n <= 3, 1);
      chk("held", drv_q.brake_release, 1'b0);
      wt(2, 1'b1);
      chk("rel", near(d[3] * MS), 1);
      wt(1, 1'b1);
      chk("run", near(d[4] * MS), 1);
      @(posedge sys_clk);
      op_enable_req <= 1'b0;
      wt(0, 1'b1);
      chk("stop", n <= 3, 1);
      chk("nomove", drv_q.motion_ok, 1'b0);
      wt(2, 1'b0);
      chk("eng", near(d[1] * MS), 1);
      chk("still on", drv_q.current_on, 1'b1);
      wt(3, 1'b0);
      chk("off", near(d[2] * MS), 1);
      if (r == 0) begin
        @(posedge sys_clk);
        op_enable_req <= 1'b1;
        wt(3, 1'b1);
        @(posedge sys_clk);
        op_enable_req <= 1'b0;
        n = 0;
        repeat (d[3] * MS + 8) begin
          @(posedge sys_clk);
          #1;
          n += (drv_q.brake_release !== 1'b0);
        end
        chk("abort", n, 0);
        chk("abort off", drv_q.current_on, 1'b0);
      end
    end
    od(1, IDX_SUBMODE, SUB_ZERO, 0);
    od(1, IDX_DOUT, SUB_ONE, 32'h1);
    chk("man rel", drv_q.brake_release, 1'b1);
    chk("man cur", drv_q.current_on, 1'b0);
    od(1, IDX_DOUT, SUB_ONE, 32'h2);
    chk("man eng", drv_q.brake_release, 1'b0);
    // Bedding in: five engagements with the motor powered; the half second is shortened.
    @(posedge sys_clk);
    op_enable_req <= 1'b1;
    for (int b = 0; b < 5; b++) begin
      od(1, IDX_DOUT, SUB_ONE, 32'h1);
      chk("bed rel", drv_q.brake_release, 1'b1);
      repeat (4 * MS) @(posedge sys_clk);
      od(1, IDX_DOUT, SUB_ONE, 32'h0);
      chk("bed eng", drv_q.brake_release, 1'b0);
      chk("bed cur", drv_q.current_on, 1'b1);
      repeat (4 * MS) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    op_enable_req <= 1'b0;
    od(1, IDX_DOUT, SUB_ONE, 32'h1);
    od(1, IDX_SUBMODE, SUB_ZERO, 32'h4);
    chk("auto held", drv_q.brake_release, 1'b0);
    od(1, IDX_MAX_MOTOR, SUB_ZERO, 32'h0BB8);
    od(1, IDX_OVERLOAD, SUB_RATED, 32'h03E8);
    od(1, IDX_OVERLOAD, SUB_PEAK, 32'h2);
    od(1, IDX_MAX_PCT, SUB_ZERO, 32'h07D0);
    od(1, IDX_SUBMODE, SUB_ZERO, 32'h5);
    @(posedge sys_clk);
    op_enable_req <= 1'b1;
    wt(1, 1'b1);
    od(0, IDX_OVERLOAD, SUB_STATUS, 0);
    chk("status", rdv, 32'h1);
    chk("act", limiter_active_q, 1'b1);
    chk("peak lim", applied_current_limit_q, 16'h07D0);
    od(0, IDX_OVERLOAD, SUB_LIMITED, 0);
    chk("lim rd", rdv, 32'h07D0);
    od(0, IDX_OVERLOAD, SUB_THRESH, 0);
    chk("thr", rdv, thr(2000));
    @(posedge sys_clk);
    cur_cmd_ma <= 16'h07D0;
    wl(16'h03E8);
    chk("fold", n >= MS - 2 && n < 4 * MS, 1);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("clamp", cur_clamp_q, 16'h03E8);
    od(0, IDX_OVERLOAD, SUB_CALC, 0);
    chk("calc", rdv, thr(2000));
    @(posedge sys_clk);
    cur_cmd_ma <= 16'h01F4;
    wl(16'h07D0);
    chk("cool", n < 3 * MS, 1);
    @(posedge sys_clk);
    cur_cmd_ma <= 16'h0000;
    for (int k = 0; k < 3; k++) begin
      pct = 1001 + {$random(seed)} % 3000;
      od(1, IDX_MAX_PCT, SUB_ZERO, pct);
      repeat (10 * MS) @(posedge sys_clk);
      #1;
      chk("cap", applied_current_limit_q, cap_of(pct));
    end
    od(1, IDX_MAX_PCT, SUB_ZERO, 32'h03E8);
    chk("eq rated", limiter_active_q, 1'b0);
    od(1, IDX_MAX_PCT, SUB_ZERO, 32'h07D0);
    od(1, IDX_OVERLOAD, SUB_PEAK, 32'h0);
    chk("no peak", limiter_active_q, 1'b0);
    od(1, IDX_OVERLOAD, SUB_PEAK, 32'h2);
    chk("again", limiter_active_q, 1'b1);
    od(1, IDX_SUBMODE, SUB_ZERO, 32'h4);
    chk("open loop", limiter_active_q, 1'b0);
    @(posedge sys_clk);
    op_enable_req <= 1'b0;
    end_of_test();
  end

  // The whole sequence takes about a thousand cycles; a hang is cut well past that.
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule // brake_sequencer_current_limiter_bench
`default_nettype wire
